// >>> hw/fwt_top.sv
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
// Summary of operation
// - each fifo raises the host interrupt when its byte count reaches the watermark
// - watermark zero disables that fifo's watermark interrupt
// - watermark above fifo capacity acts as equal to capacity
// - fifo control block holds two watermarks and two read-only sizes
// - low latency with host awake makes watermark ineffective
// - firmware version gives 20 read-only bytes: version and three hashes
// - timestamps are 40-bit counts of 1/64000 s
// - system time latched on each host interrupt, readable
// - current system time readable after interrupt timestamp
// - write to event request latches system time into event field
// - latched interrupt timestamp also in dedicated direct registers
// - timestamp block reports payload length sixteen
// - meta control two bits per event: fifo enable high, interrupt enable low
module fwt_top
	import fwt_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [31:0] wk_level,
	input wire logic [31:0] nw_level,
	input wire logic [31:0] meta_event,
	output logic [31:0] meta_fifo_en,
	output logic [31:0] meta_int_now,
	output logic host_suspended_flag,
	output logic host_irq
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [31:0] wk_wmark, next_wk_wmark;
	logic [31:0] nw_wmark, next_nw_wmark;
	logic [1:0] ctrl, next_ctrl;
	logic [63:0] meta_nw, next_meta_nw;
	logic [63:0] meta_wk, next_meta_wk;
	logic [IRQ_WIDTH-1:0] irq_stat, next_irq_stat;
	logic [IRQ_WIDTH-1:0] irq_mask, next_irq_mask;
	logic [TS_WIDTH-1:0] ts_now, next_ts_now;
	logic [TS_WIDTH-1:0] ts_hint, next_ts_hint;
	logic [TS_WIDTH-1:0] ts_event, next_ts_event;
	logic [15:0] tick_cnt, next_tick_cnt;
	logic irq_q, next_irq_q;
	logic [31:0] rdata_q, next_rdata_q;
	logic err_q, next_err_q;
	logic ready_q, next_ready_q;
	logic [31:0] fifo_en_q, next_fifo_en_q;
	logic [31:0] int_now_q, next_int_now_q;
	logic wk_hit, nw_hit;
	logic lat_gate;
	logic wr_acc, rd_acc;
	logic [31:0] meta_hit;
	logic meta_irq;
	logic irq_rise;

	// extract one event bit from a meta control map, upper or lower
	function automatic logic meta_bit(input logic [63:0] map, input int ev, input logic hi);
		meta_bit = map[2*ev + (hi ? 1 : 0)];
	endfunction

	// ----------------------------------------
	// watermark compare
	// ----------------------------------------
	// low latency while host is awake silences the watermark
	assign lat_gate = ctrl[CTRL_LOWLAT_BIT] && !ctrl[CTRL_SUSPEND_BIT];
	fwt_wmark u_wk (
		.level(wk_level),
		.wmark(wk_wmark),
		.capacity(WK_FIFO_SIZE),
		.gate_off(lat_gate),
		.hit(wk_hit)
	);
	fwt_wmark u_nw (
		.level(nw_level),
		.wmark(nw_wmark),
		.capacity(NW_FIFO_SIZE),
		.gate_off(lat_gate),
		.hit(nw_hit)
	);

	// ----------------------------------------
	// meta event decode
	// ----------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 32; gi++) begin : g_meta
			// upper bit is fifo enable, lower bit is immediate interrupt
			assign meta_hit[gi] = meta_event[gi] &&
				(meta_bit(meta_nw, gi, 1'b0) || meta_bit(meta_wk, gi, 1'b0));
		end
	endgenerate
	assign meta_irq = |meta_hit;

	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	// a write lands only at the access edge that samples pready high
	assign wr_acc = psel && penable && pwrite && ready_q;
	assign rd_acc = psel && !penable && !pwrite;

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		next_wk_wmark = wk_wmark;
		next_nw_wmark = nw_wmark;
		next_ctrl = ctrl;
		next_meta_nw = meta_nw;
		next_meta_wk = meta_wk;
		next_irq_mask = irq_mask;
		next_irq_stat = irq_stat;
		next_ts_event = ts_event;
		next_rdata_q = rdata_q;
		next_err_q = 1'b0;
		next_ready_q = psel && !penable;
		// timebase: divide to 1/64000 s and wrap
		if (tick_cnt == 16'(TICK_CYCLES - 1)) begin
			next_tick_cnt = 16'h0000;
			next_ts_now = ts_now + 40'h00_0000_0001;
		end else begin
			next_tick_cnt = tick_cnt + 16'h0001;
			next_ts_now = ts_now;
		end
		// register writes, write one to clear status
		if (wr_acc) begin
			unique case (paddr)
				OFS_WK_WMARK: next_wk_wmark = pwdata;
				OFS_NW_WMARK: next_nw_wmark = pwdata;
				OFS_CTRL: next_ctrl = pwdata[1:0];
				OFS_META_NW0: next_meta_nw[31:0] = pwdata;
				OFS_META_NW1: next_meta_nw[63:32] = pwdata;
				OFS_META_WK0: next_meta_wk[31:0] = pwdata;
				OFS_META_WK1: next_meta_wk[63:32] = pwdata;
				OFS_IRQ_MASK: next_irq_mask = pwdata[IRQ_WIDTH-1:0];
				OFS_IRQ_STAT: next_irq_stat = irq_stat & ~pwdata[IRQ_WIDTH-1:0];
				OFS_TSE_REQ: begin
					next_ts_event = ts_now;
				end
				default: ;
			endcase
		end
		// hardware sets win over software clear
		if (wk_hit || meta_irq) next_irq_stat[IRQ_WK_BIT] = 1'b1;
		if (nw_hit) next_irq_stat[IRQ_NW_BIT] = 1'b1;
		if (wr_acc && paddr == OFS_TSE_REQ) next_irq_stat[IRQ_TSE_BIT] = 1'b1;
		// read data captured in setup phase
		if (rd_acc) begin
			next_rdata_q = 32'h0000_0000;
			if (paddr >= OFS_FW_BASE && paddr < OFS_FW_BASE + 12'(4 * FW_WORDS) &&
				paddr[1:0] == 2'b00) begin
				// firmware words, high word first
				next_rdata_q = FW_ID_VALUE[32*(FW_WORDS-1-int'((paddr - OFS_FW_BASE) >> 2)) +: 32];
			end else begin
				unique case (paddr)
					OFS_WK_WMARK: next_rdata_q = wk_wmark;
					OFS_WK_SIZE: next_rdata_q = WK_FIFO_SIZE;
					OFS_NW_WMARK: next_rdata_q = nw_wmark;
					OFS_NW_SIZE: next_rdata_q = NW_FIFO_SIZE;
					OFS_FIFO_LEN: next_rdata_q = FIFO_PAYLOAD_LEN;
					OFS_WK_LEVEL: next_rdata_q = wk_level;
					OFS_NW_LEVEL: next_rdata_q = nw_level;
					OFS_CTRL: next_rdata_q = {30'h0000_0000, ctrl};
					OFS_TS_LEN: next_rdata_q = TS_PAYLOAD_LEN;
					OFS_HIT_LO: next_rdata_q = ts_hint[31:0];
					OFS_HIT_HI: next_rdata_q = {24'h00_0000, ts_hint[39:32]};
					OFS_CUR_LO: next_rdata_q = ts_now[31:0];
					OFS_CUR_HI: next_rdata_q = {24'h00_0000, ts_now[39:32]};
					OFS_TSE_LO: next_rdata_q = ts_event[31:0];
					OFS_TSE_HI: next_rdata_q = {24'h00_0000, ts_event[39:32]};
					OFS_TSE_REQ: next_rdata_q = 32'h0000_0000;
					OFS_FW_LEN: next_rdata_q = FW_PAYLOAD_LEN;
					OFS_META_NW0: next_rdata_q = meta_nw[31:0];
					OFS_META_NW1: next_rdata_q = meta_nw[63:32];
					OFS_META_WK0: next_rdata_q = meta_wk[31:0];
					OFS_META_WK1: next_rdata_q = meta_wk[63:32];
					OFS_IRQ_STAT: next_rdata_q = {29'h0000_0000, irq_stat};
					OFS_IRQ_MASK: next_rdata_q = {29'h0000_0000, irq_mask};
					OFS_HIT_DIRECT_LO: next_rdata_q = ts_hint[31:0];
					OFS_HIT_DIRECT_HI: next_rdata_q = {24'h00_0000, ts_hint[39:32]};
					default: next_err_q = 1'b1;
				endcase
			end
		end else if (psel && !penable) begin
			// write to unmapped or read-only address
			unique case (paddr)
				OFS_WK_WMARK, OFS_NW_WMARK, OFS_CTRL, OFS_META_NW0, OFS_META_NW1,
				OFS_META_WK0, OFS_META_WK1, OFS_IRQ_MASK, OFS_IRQ_STAT,
				OFS_TSE_REQ: next_err_q = 1'b0;
				default: next_err_q = 1'b1;
			endcase
		end
		if (!(psel && !penable)) next_err_q = err_q && psel && penable && !ready_q;
		// interrupt output and its timestamp latch
		next_irq_q = |(next_irq_stat & irq_mask);
		irq_rise = next_irq_q && !irq_q;
		next_ts_hint = irq_rise ? ts_now : ts_hint;
		// meta enable outputs
		for (int i = 0; i < 32; i++) begin
			next_fifo_en_q[i] = meta_bit(meta_nw, i, 1'b1) || meta_bit(meta_wk, i, 1'b1);
			next_int_now_q[i] = meta_bit(meta_nw, i, 1'b0) || meta_bit(meta_wk, i, 1'b0);
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wk_wmark <= 32'h0000_0000;
			nw_wmark <= 32'h0000_0000;
			ctrl <= CTRL_RESET;
			meta_nw <= META_RESET;
			meta_wk <= META_RESET;
			irq_stat <= 3'h0;
			irq_mask <= 3'h0;
			ts_now <= 40'h00_0000_0000;
			ts_hint <= 40'h00_0000_0000;
			ts_event <= 40'h00_0000_0000;
			tick_cnt <= 16'h0000;
			irq_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			err_q <= 1'b0;
			ready_q <= 1'b0;
			fifo_en_q <= 32'h0000_0000;
			int_now_q <= 32'h0000_0000;
		end else begin
			wk_wmark <= next_wk_wmark;
			nw_wmark <= next_nw_wmark;
			ctrl <= next_ctrl;
			meta_nw <= next_meta_nw;
			meta_wk <= next_meta_wk;
			irq_stat <= next_irq_stat;
			irq_mask <= next_irq_mask;
			ts_now <= next_ts_now;
			ts_hint <= next_ts_hint;
			ts_event <= next_ts_event;
			tick_cnt <= next_tick_cnt;
			irq_q <= next_irq_q;
			rdata_q <= next_rdata_q;
			err_q <= next_err_q;
			ready_q <= next_ready_q;
			fifo_en_q <= next_fifo_en_q;
			int_now_q <= next_int_now_q;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign prdata = rdata_q;
	assign pready = ready_q;
	assign pslverr = err_q; // err_q only stands in the access cycle
	assign host_irq = irq_q;
	assign host_suspended_flag = ctrl[CTRL_SUSPEND_BIT];
	assign meta_fifo_en = fifo_en_q;
	assign meta_int_now = int_now_q;
endmodule // fwt_top

// >>> common/fwt_pkg.sv
package fwt_pkg;
	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [11:0] OFS_WK_WMARK = 12'h000;
	localparam logic [11:0] OFS_WK_SIZE = 12'h004;
	localparam logic [11:0] OFS_NW_WMARK = 12'h008;
	localparam logic [11:0] OFS_NW_SIZE = 12'h00c;
	localparam logic [11:0] OFS_FIFO_LEN = 12'h010;
	localparam logic [11:0] OFS_WK_LEVEL = 12'h014;
	localparam logic [11:0] OFS_NW_LEVEL = 12'h018;
	localparam logic [11:0] OFS_CTRL = 12'h01c;
	localparam logic [11:0] OFS_TS_LEN = 12'h020;
	localparam logic [11:0] OFS_HIT_LO = 12'h024;
	localparam logic [11:0] OFS_HIT_HI = 12'h028;
	localparam logic [11:0] OFS_CUR_LO = 12'h02c;
	localparam logic [11:0] OFS_CUR_HI = 12'h030;
	localparam logic [11:0] OFS_TSE_LO = 12'h034;
	localparam logic [11:0] OFS_TSE_HI = 12'h038;
	localparam logic [11:0] OFS_TSE_REQ = 12'h03c;
	localparam logic [11:0] OFS_FW_LEN = 12'h040;
	localparam logic [11:0] OFS_FW_BASE = 12'h044;
	localparam logic [11:0] OFS_META_NW0 = 12'h05c;
	localparam logic [11:0] OFS_META_NW1 = 12'h060;
	localparam logic [11:0] OFS_META_WK0 = 12'h064;
	localparam logic [11:0] OFS_META_WK1 = 12'h068;
	localparam logic [11:0] OFS_IRQ_STAT = 12'h06c;
	localparam logic [11:0] OFS_IRQ_MASK = 12'h070;
	localparam logic [11:0] OFS_HIT_DIRECT_LO = 12'h074;
	localparam logic [11:0] OFS_HIT_DIRECT_HI = 12'h078;
	// ----------------------------------------
	// payload lengths and sizes
	// ----------------------------------------
	localparam logic [31:0] FIFO_PAYLOAD_LEN = 32'h0000_0010;
	localparam logic [31:0] TS_PAYLOAD_LEN = 32'h0000_0010;
	localparam logic [31:0] FW_PAYLOAD_LEN = 32'h0000_0014;
	localparam logic [31:0] WK_FIFO_SIZE = 32'h0000_0800;
	localparam logic [31:0] NW_FIFO_SIZE = 32'h0000_0800;
	localparam int FW_WORDS = 5;
	// firmware identity, values are arbitrary
	localparam logic [159:0] FW_ID_VALUE = 160'h0001_1111_1111_1111_2222_2222_2222_3333_3333_3333;
	// ----------------------------------------
	// control and status fields
	// ----------------------------------------
	localparam int CTRL_SUSPEND_BIT = 0;
	localparam int CTRL_LOWLAT_BIT = 1;
	localparam int IRQ_WK_BIT = 0;
	localparam int IRQ_NW_BIT = 1;
	localparam int IRQ_TSE_BIT = 2;
	localparam int IRQ_WIDTH = 3;
	localparam logic [1:0] CTRL_RESET = 2'h0;
	localparam logic [63:0] META_RESET = 64'h0000_0000_0000_0000;
	// ----------------------------------------
	// time base
	// ----------------------------------------
	localparam int CLK_HZ = 50000000;
	localparam int TICK_HZ = 64000;
	localparam int TICK_CYCLES = CLK_HZ / TICK_HZ;
	localparam int TS_WIDTH = 40;
endpackage : fwt_pkg

// >>> hw/fwt_wmark.sv
`timescale 1ns/1ps
module fwt_wmark
	import fwt_pkg::*;
(
	input wire logic [31:0] level,
	input wire logic [31:0] wmark,
	input wire logic [31:0] capacity,
	input wire logic gate_off,
	output logic hit
);
	// ----------------------------------------
	// watermark compare
	// ----------------------------------------
	logic [31:0] eff;
	// clamp to capacity, zero disables, level compare is continuous
	always_comb begin
		eff = (wmark > capacity) ? capacity : wmark;
		hit = (wmark != 32'h0000_0000) && !gate_off && (level >= eff);
	end
endmodule // fwt_wmark

// >>> test/fwt_top_sva.sv
`timescale 1ns/1ps
module fwt_top_sva
	import fwt_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic host_suspended_flag
);
	// ----------------------------------------
	// access checks
	// ----------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic acc;
	assign acc = psel && penable && pready;
	a_ro_size_err: assert property (acc && pwrite && paddr == OFS_WK_SIZE |-> pslverr)
		else $error("size write not refused");
	a_wk_size: assert property (acc && !pwrite && paddr == OFS_WK_SIZE |-> prdata == WK_FIFO_SIZE)
		else $error("wake size wrong");
	a_nw_size: assert property (acc && !pwrite && paddr == OFS_NW_SIZE |-> prdata == NW_FIFO_SIZE)
		else $error("non-wake size wrong");
	a_fifo_len: assert property (acc && !pwrite && paddr == OFS_FIFO_LEN |-> prdata == 32'h10)
		else $error("fifo length wrong");
	a_ts_len: assert property (acc && !pwrite && paddr == OFS_TS_LEN |-> prdata == 32'h10)
		else $error("timestamp length wrong");
	a_fw_len: assert property (acc && !pwrite && paddr == OFS_FW_LEN |-> prdata == 32'h14)
		else $error("firmware length wrong");
	a_time_width: assert property (acc && !pwrite && paddr == OFS_CUR_HI |-> prdata[31:8] == 24'h0)
		else $error("time wider than 40 bits");
	a_susp_flag: assert property (acc && pwrite && paddr == OFS_CTRL
		|=> host_suspended_flag == $past(pwdata[CTRL_SUSPEND_BIT]))
		else $error("suspend flag not taken");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
endmodule // fwt_top_sva
bind fwt_top fwt_top_sva i_fwt_top_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .host_suspended_flag(host_suspended_flag));

// >>> test/fwt_host.sv
`timescale 1ns/1ps
module fwt_host (
	input wire logic pclk,
	input wire logic pready,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata
);
	initial begin
		psel = 0;
		penable = 0;
		pwrite = 0;
		paddr = 12'h0;
		pwdata = 32'h0;
	end
	// one apb transfer, held until pready is sampled
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 0;
		penable <= 0;
		pwdata <= ~d; // released data does not linger
		@(posedge pclk);
	endtask
endmodule // fwt_host

// >>> test/fwt_top_test.sv
`timescale 1ns/1ps
module fwt_top_test;
	import fwt_pkg::*;
	logic pclk = 0, presetn = 0, psel, penable, pwrite, pready, pslverr, susp, irq, irq_q = 0;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, fen, inow, meta = 32'h0, w, df;
	logic [31:0] lv [2] = '{32'h0, 32'h0};
	logic [34:0] q [$];
	logic [34:0] e;
	logic [11:0] wa;
	int fails = 0, compares = 0, cyc = 0, hit = 0;
	initial forever #10 pclk = ~pclk;
	fwt_top i_fwt_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .wk_level(lv[0]), .nw_level(lv[1]), .meta_event(meta),
		.meta_fifo_en(fen), .meta_int_now(inow), .host_suspended_flag(susp), .host_irq(irq));
	fwt_host i_fwt_host (.pclk(pclk), .pready(pready), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
	task check(input string n, input logic [31:0] s, input logic [31:0] x);
		compares++;
		if (s !== x) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", n, x, s);
		end
	endtask
	task conclude();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// note the expected answer, then run the transfer
	task op(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic er, ap);
		q.push_back({ap, !wr, er, wr ? 32'h0 : d});
		i_fwt_host.xfer(wr, a, d);
	endtask
	task irqchk(input logic x);
		repeat (4) @(posedge pclk);
		check("host_irq", {31'h0, irq}, {31'h0, x});
	endtask
	// ----------------------------------------
	// watcher, cycle count and timeout
	// ----------------------------------------
	always @(posedge pclk) begin
		cyc <= presetn ? cyc + 1 : 0;
		irq_q <= irq;
		if (irq && !irq_q) hit <= cyc;
		if (cyc > 20000) begin
			fails++;
			conclude();
		end
		if (psel && penable && pready === 1'b1) begin
			e = q.pop_front();
			df = prdata - e[31:0];
			check("pslverr", {31'h0, pslverr}, {31'h0, e[32]});
			if (e[33] && e[34]) check("time", {31'h0, df <= 1 || df == '1}, 32'h1);
			else if (e[33]) check("prdata", prdata, e[31:0]);
		end
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(86393));
		repeat (2) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		op(0, OFS_WK_SIZE, WK_FIFO_SIZE, 0, 0);
		op(0, OFS_NW_SIZE, NW_FIFO_SIZE, 0, 0);
		op(0, OFS_FIFO_LEN, 32'h10, 0, 0);
		op(0, OFS_TS_LEN, 32'h10, 0, 0);
		op(0, OFS_FW_LEN, 32'h14, 0, 0);
		for (int k = 0; k < 5; k++) op(0, OFS_FW_BASE + 12'(4 * k), FW_ID_VALUE[159 - 32 * k -: 32], 0, 0);
		op(1, OFS_NW_SIZE, 32'h1, 1, 0);
		op(1, OFS_WK_SIZE, 32'h1, 1, 0);
		op(0, 12'h07c, 32'h0, 1, 0);
		op(1, OFS_IRQ_MASK, 32'h7, 0, 0);
		for (int k = 0; k < 2; k++) begin
			wa = k ? OFS_NW_WMARK : OFS_WK_WMARK;
			w = 32'h1 + ($urandom % 32'h7ff);
			lv[k] <= 32'h7ff;
			irqchk(0);
			lv[k] <= w - 1;
			op(1, wa, w, 0, 0);
			irqchk(0);
			lv[k] <= w;
			op(0, k ? OFS_NW_LEVEL : OFS_WK_LEVEL, w, 0, 0);
			irqchk(1);
			op(1, OFS_IRQ_STAT, 32'h7, 0, 0);
			irqchk(1);
			op(0, wa, w, 0, 0);
			op(1, wa, 32'hffff, 0, 0);
			lv[k] <= 32'h7ff;
			op(1, OFS_IRQ_STAT, 32'h7, 0, 0);
			irqchk(0);
			lv[k] <= 32'h800;
			irqchk(1);
			lv[k] <= 0;
			op(1, OFS_IRQ_STAT, 32'h7, 0, 0);
			irqchk(0);
		end
		op(1, OFS_CTRL, 32'h2, 0, 0);
		lv[0] <= 32'h800;
		irqchk(0);
		op(1, OFS_CTRL, 32'h3, 0, 0);
		irqchk(1);
		op(0, OFS_HIT_LO, hit / TICK_CYCLES, 0, 1);
		op(0, OFS_HIT_DIRECT_LO, hit / TICK_CYCLES, 0, 1);
		repeat (2000) @(posedge pclk);
		op(1, OFS_TSE_REQ, 32'h0, 0, 0);
		op(0, OFS_TSE_LO, cyc / TICK_CYCLES, 0, 1);
		op(0, OFS_CUR_LO, cyc / TICK_CYCLES, 0, 1);
		op(0, OFS_CUR_HI, 32'h0, 0, 0);
		op(1, OFS_META_WK0, 32'h3, 0, 0);
		lv[0] <= 32'h0;
		op(1, OFS_IRQ_STAT, 32'h7, 0, 0);
		irqchk(0);
		meta <= 32'h1;
		@(posedge pclk);
		meta <= 32'h0;
		irqchk(1);
		check("fifo_en", fen, 32'h1);
		check("int_now", inow, 32'h1);
		conclude();
	end
endmodule // fwt_top_test
